// ### pkg/ccbi_defines.vh
// Constants for the codec control byte interpreter
`ifndef CCBI_DEFINES_VH
`define CCBI_DEFINES_VH
// Control byte fields
`define CCBI_CB_ADDR 7
`define CCBI_CB_RW 6
`define CCBI_CB_PWR 5
`define CCBI_CB_CONF 4
`define CCBI_CB_B3 3
`define CCBI_CB_B2 2
// Length codes
`define CCBI_LEN_NONE 2'h0
`define CCBI_LEN_UNUSED 2'h1
`define CCBI_LEN_TWO 2'h2
`define CCBI_LEN_ONE 2'h3
// Reset values
`define CCBI_CFG1_RST 8'h00
`define CCBI_CFG2_RST 8'hFF
// First configuration register fields
`define CCBI_C1_BOFF 7
`define CCBI_C1_ZON 6
`define CCBI_C1_XON 5
`define CCBI_C1_RON 4
`define CCBI_C1_GON 3
// Second configuration register fields
`define CCBI_C2_DIR_HI 7
`define CCBI_C2_DIR_LO 4
`define CCBI_C2_EXP 3
`define CCBI_C2_SINGLE 2
`define CCBI_C2_MULAW 1
`define CCBI_C2_FIXB 0
// Coefficient write codes (address bit clear)
`define CCBI_CW_B1 8'h03
`define CCBI_CW_B2 8'h0B
`define CCBI_CW_BD 8'h18
`define CCBI_CW_Z 8'h13
`define CCBI_CW_X 8'h23
`define CCBI_CW_R 8'h2B
`define CCBI_CW_G 8'h30
// Coefficient read codes
`define CCBI_CR_B1 8'h43
`define CCBI_CR_B2 8'h4B
`define CCBI_CR_BD 8'h58
`define CCBI_CR_Z 8'h53
`define CCBI_CR_X 8'h63
`define CCBI_CR_R 8'h6B
`define CCBI_CR_G 8'h70
// Status read code
`define CCBI_STATUS_READ 8'h66
// Coefficient block lengths in bytes
`define CCBI_LEN_8 4'h8
`define CCBI_LEN_4 4'h4
`endif

// ### core/ccbi_sync3.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ccbi_sync3 #(
    parameter W = 1
) (
    input wire clk, // System clock
    input wire rst_n, // Async reset, active low
    input wire [W-1:0] d, // Asynchronous input
    output reg [W-1:0] q // Filtered level
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    // A change counts only once stages two and three agree
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end
        else
        begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q <= (s2_reg == s3_reg) ? s3_reg : q;
        end
    end
endmodule // ccbi_sync3
`default_nettype wire

// ### core/ccbi_top.v
// Codec control byte interpreter: command decode, config and coefficient RAM
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - Bits 3 and 2 classify a byte as idle, status or coefficient.
// - Bit 7 addresses one of two codecs; single codec expects zero.
// - Status read/write bit: one reads configuration, zero writes it.
// - Power bit one means operating, zero means standby.
// - Conference bit one sums received channel A and B voice bytes.
// - Length 00 none, 11 one byte to cfg1, 10 cfg2 then cfg1.
// - Cfg1 bit 7 one disables the balance filter.
// - Cfg1 bits 6..3 enable impedance, transmit, receive, gain filters.
// - Cfg1 low bits select test mode; 100 and 101 unused.
// - Cfg2 bits 7..4 make pins D, C, B, A inputs when one.
// - Cfg2 bit 3 marks signaling expansion logic attached.
// - Cfg2 bit 2 one single codec; zero forces pin A input.
// - Cfg2 bit 1 selects mu-law when one, A-law when zero.
// - Cfg2 bit 0 selects fixed balance coefficients when one.
// - Reset clears cfg1 and sets every cfg2 bit.
// - Status read returns cfg2 then cfg1.
// - Coefficient write codes 03,0B,18,13,23,2B,30; bit 7 for second codec.
// - Coefficient read codes 43,4B,58,53,63,6B,70 in the same order.
// - A coefficient read ends with cfg2 then cfg1.
// - Status read is requested with byte 66.
// - Signaling byte: fixed bits 7..5, pins D..A 4..1, expansion bit 0.
// - Three fixed inputs, three fixed outputs, four programmable pins.
// - With two codecs pin A level names the addressed codec.
//
`include "ccbi_defines.vh"
module ccbi_top #(
    parameter RAM_DEPTH = 64
) (
    input wire CLK_SYS, // System clock, 20 MHz
    input wire RSTN, // Async reset, active low
    input wire [7:0] RX_BYTE, // Byte from controller port
    input wire RX_VALID, // One-cycle strobe with RX_BYTE
    input wire [7:0] SIG_RX_BYTE, // Receive signaling byte
    input wire SIG_RX_VALID, // Strobe with SIG_RX_BYTE
    input wire [2:0] SIG_IN_PINS, // Fixed transmit signaling inputs 1..3
    input wire [3:0] SIG_PIN_IN, // Pins D,C,B,A levels
    input wire [7:0] VOICE_A, // Received voice byte channel A
    input wire [7:0] VOICE_B, // Received voice byte channel B
    output reg [7:0] TX_BYTE, // Byte returned to controller port
    output reg TX_VALID, // One-cycle strobe with TX_BYTE
    output reg [7:0] SIG_TX_BYTE, // Transmit signaling byte
    output reg [2:0] SIG_OUT_PINS, // Fixed receive signaling outputs 1..3
    output reg [3:0] SIG_PIN_OUT, // Pins D,C,B,A drive value
    output reg [3:0] SIG_PIN_OE, // Pins D,C,B,A output enable
    output reg SIG_EXP_OUT, // Expansion bit to expansion logic
    output reg [7:0] VOICE_SUM, // Voice sum or channel A
    output reg POWER_UP, // Operating when high
    output reg [7:0] FILTER_AND_TEST_CONFIG, // First config register
    output reg [7:0] SIGNALING_AND_LAW_CONFIG, // Second config register
    output reg [2:0] TEST_MODE, // Effective test mode
    output reg MU_LAW, // Mu-law companding selected
    output reg FIXED_BALANCE // Fixed balance coefficients
);
    localparam AW = 6;
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_CFG = 5'h02;
    localparam [4:0] ST_CWR = 5'h04;
    localparam [4:0] ST_CRD = 5'h08;
    localparam [4:0] ST_TAIL = 5'h10;

    reg [4:0] state_reg;
    reg [1:0] cfg_cnt_reg;
    reg [3:0] cnt_reg;
    reg [AW-1:0] ptr_reg;
    reg conf_reg;
    reg [7:0] cfg1_reg;
    reg [7:0] cfg2_reg;
    reg [7:0] ram [0:RAM_DEPTH-1];
    wire [3:0] pin_s;
    wire [2:0] sin_s;
    reg [AW-1:0] base;
    reg [3:0] blen;
    reg is_wr;
    reg is_rd;
    wire for_me;
    wire [7:0] low7;

    ccbi_sync3 #(.W(4)) u_pin_sync (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .d(SIG_PIN_IN),
        .q(pin_s)
    );
    ccbi_sync3 #(.W(3)) u_sin_sync (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .d(SIG_IN_PINS),
        .q(sin_s)
    );

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Address bit masked so both codec positions share one code table
    assign low7 = {1'b0, RX_BYTE[6:0]};
    assign for_me = cfg2_reg[`CCBI_C2_SINGLE] ? ~RX_BYTE[`CCBI_CB_ADDR]
        : (RX_BYTE[`CCBI_CB_ADDR] == pin_s[0]);

    always @*
    begin
        base = 6'h00;
        blen = 4'h0;
        is_wr = 1'b0;
        is_rd = 1'b0;
        if (low7 == `CCBI_CW_B1 || low7 == `CCBI_CR_B1)
        begin
            base = 6'h00;
            blen = `CCBI_LEN_8;
        end
        else if (low7 == `CCBI_CW_B2 || low7 == `CCBI_CR_B2)
        begin
            base = 6'h08;
            blen = `CCBI_LEN_8;
        end
        else if (low7 == `CCBI_CW_BD || low7 == `CCBI_CR_BD)
        begin
            base = 6'h10;
            blen = `CCBI_LEN_4;
        end
        else if (low7 == `CCBI_CW_Z || low7 == `CCBI_CR_Z)
        begin
            base = 6'h18;
            blen = `CCBI_LEN_8;
        end
        else if (low7 == `CCBI_CW_X || low7 == `CCBI_CR_X)
        begin
            base = 6'h20;
            blen = `CCBI_LEN_8;
        end
        else if (low7 == `CCBI_CW_R || low7 == `CCBI_CR_R)
        begin
            base = 6'h28;
            blen = `CCBI_LEN_8;
        end
        else if (low7 == `CCBI_CW_G || low7 == `CCBI_CR_G)
        begin
            base = 6'h30;
            blen = `CCBI_LEN_4;
        end
        if (blen != 4'h0)
        begin
            is_rd = RX_BYTE[`CCBI_CB_RW];
            is_wr = ~RX_BYTE[`CCBI_CB_RW];
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_reg <= ST_IDLE;
            cfg_cnt_reg <= 2'h0;
            cnt_reg <= 4'h0;
            ptr_reg <= {AW{1'b0}};
            conf_reg <= 1'b0;
            POWER_UP <= 1'b0;
            cfg1_reg <= `CCBI_CFG1_RST;
            cfg2_reg <= `CCBI_CFG2_RST;
            TX_BYTE <= 8'h00;
            TX_VALID <= 1'b0;
        end
        else
        begin
            TX_VALID <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    // class by bits 3 and 2
                    if (RX_VALID && for_me && RX_BYTE[`CCBI_CB_B2]
                        && !RX_BYTE[`CCBI_CB_B3])
                    begin
                        POWER_UP <= RX_BYTE[`CCBI_CB_PWR];
                        conf_reg <= RX_BYTE[`CCBI_CB_CONF];
                        if (RX_BYTE[`CCBI_CB_RW])
                        begin
                            TX_BYTE <= cfg2_reg;
                            TX_VALID <= 1'b1;
                            state_reg <= ST_TAIL;
                        end
                        else if (RX_BYTE[1:0] == `CCBI_LEN_ONE)
                        begin
                            cfg_cnt_reg <= 2'h1;
                            state_reg <= ST_CFG;
                        end
                        else if (RX_BYTE[1:0] == `CCBI_LEN_TWO)
                        begin
                            cfg_cnt_reg <= 2'h2;
                            state_reg <= ST_CFG;
                        end
                    end
                    else if (RX_VALID && for_me && !RX_BYTE[`CCBI_CB_B2])
                    begin
                        ptr_reg <= base;
                        cnt_reg <= blen;
                        if (is_wr)
                            state_reg <= ST_CWR;
                        else if (is_rd)
                        begin
                            TX_BYTE <= ram[base];
                            TX_VALID <= 1'b1;
                            ptr_reg <= base + 6'h01;
                            cnt_reg <= blen - 4'h1;
                            state_reg <= ST_CRD;
                        end
                    end
                end
                ST_CFG:
                begin
                    if (RX_VALID)
                    begin
                        // second register first when two bytes
                        if (cfg_cnt_reg == 2'h2)
                            cfg2_reg <= RX_BYTE;
                        else
                            cfg1_reg <= RX_BYTE;
                        cfg_cnt_reg <= cfg_cnt_reg - 2'h1;
                        if (cfg_cnt_reg == 2'h1)
                            state_reg <= ST_IDLE;
                    end
                end
                ST_CWR:
                begin
                    if (RX_VALID)
                    begin
                        ptr_reg <= ptr_reg + 6'h01;
                        cnt_reg <= cnt_reg - 4'h1;
                        if (cnt_reg == 4'h1)
                            state_reg <= ST_IDLE;
                    end
                end
                ST_CRD:
                begin
                    // One returned byte per cycle; the port paces itself on TX_VALID
                    if (cnt_reg == 4'h0)
                    begin
                        TX_BYTE <= cfg2_reg;
                        TX_VALID <= 1'b1;
                        state_reg <= ST_TAIL;
                    end
                    else
                    begin
                        TX_BYTE <= ram[ptr_reg];
                        TX_VALID <= 1'b1;
                        ptr_reg <= ptr_reg + 6'h01;
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                ST_TAIL:
                begin
                    TX_BYTE <= cfg1_reg;
                    TX_VALID <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Coefficient RAM
    // ------------------------------------------------------------
    // No reset: the RAM holds whatever the controller last loaded
    always @(posedge CLK_SYS)
    begin
        if (state_reg == ST_CWR && RX_VALID)
            ram[ptr_reg] <= RX_BYTE;
    end

    // ------------------------------------------------------------
    // Configuration outputs and signaling
    // ------------------------------------------------------------
    always @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            FILTER_AND_TEST_CONFIG <= `CCBI_CFG1_RST;
            SIGNALING_AND_LAW_CONFIG <= `CCBI_CFG2_RST;
            TEST_MODE <= 3'h0;
            MU_LAW <= 1'b1;
            FIXED_BALANCE <= 1'b1;
            SIG_PIN_OE <= 4'h0;
            SIG_PIN_OUT <= 4'h0;
            SIG_OUT_PINS <= 3'h0;
            SIG_EXP_OUT <= 1'b0;
            SIG_TX_BYTE <= 8'h00;
            VOICE_SUM <= 8'h00;
        end
        else
        begin
            FILTER_AND_TEST_CONFIG <= cfg1_reg;
            SIGNALING_AND_LAW_CONFIG <= cfg2_reg;
            // unused test codes act as none
            TEST_MODE <= (cfg1_reg[2:1] == 2'h2) ? 3'h0 : cfg1_reg[2:0];
            MU_LAW <= cfg2_reg[`CCBI_C2_MULAW];
            FIXED_BALANCE <= cfg2_reg[`CCBI_C2_FIXB];
            // pin direction, pin A forced input when cfg2 bit 2 is zero
            SIG_PIN_OE <= ~cfg2_reg[`CCBI_C2_DIR_HI:`CCBI_C2_DIR_LO]
                & {3'h7, cfg2_reg[`CCBI_C2_SINGLE]};
            if (SIG_RX_VALID)
            begin
                SIG_OUT_PINS <= SIG_RX_BYTE[7:5];
                SIG_PIN_OUT <= SIG_RX_BYTE[4:1];
                // expansion bit only with expansion logic
                SIG_EXP_OUT <= SIG_RX_BYTE[0] & cfg2_reg[`CCBI_C2_EXP];
            end
            // transmit byte; output pins read back as zero
            SIG_TX_BYTE <= {sin_s, pin_s & ~SIG_PIN_OE, 1'b0};
            VOICE_SUM <= conf_reg ? (VOICE_A + VOICE_B) : VOICE_A;
        end
    end
endmodule // ccbi_top
`default_nettype wire

// ### sim/ccbi_ctrl_model.sv
// Board controller model driving the serial codec port
`timescale 1ns/1ps
`default_nettype none
module ccbi_ctrl_model (
    input wire logic clk, // System clock
    output logic [7:0] rx_byte, // Byte to device
    output logic rx_valid // Byte strobe
);
    initial
    begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    task send(input logic [7:0] b);
    begin
        @(posedge clk);
        rx_byte <= b;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        // Released port shows the inverse so a stale byte is never reused
        rx_byte <= ~b;
    end
    endtask
endmodule // ccbi_ctrl_model
`default_nettype wire

// ### sim/ccbi_top_chk.sv
// Port assertions for the codec control byte interpreter
`timescale 1ns/1ps
`default_nettype none
module ccbi_top_chk (
    input wire logic CLK_SYS, // Clock
    input wire logic RSTN, // Reset, active low
    input wire logic RX_VALID, // Byte strobe
    input wire logic [7:0] SIG_RX_BYTE, // Rx signaling
    input wire logic SIG_RX_VALID, // Rx strobe
    input wire logic [7:0] TX_BYTE, // Reply byte
    input wire logic TX_VALID, // Reply strobe
    input wire logic [7:0] SIG_TX_BYTE, // Tx signaling
    input wire logic [2:0] SIG_OUT_PINS, // Fixed outputs
    input wire logic [3:0] SIG_PIN_OUT, // Pin drive
    input wire logic [3:0] SIG_PIN_OE, // Pin enable
    input wire logic SIG_EXP_OUT, // Expansion bit
    input wire logic [7:0] FILTER_AND_TEST_CONFIG, // Cfg1
    input wire logic [7:0] SIGNALING_AND_LAW_CONFIG, // Cfg2
    input wire logic [2:0] TEST_MODE, // Test mode
    input wire logic MU_LAW, // Mu-law
    input wire logic FIXED_BALANCE // Fixed balance
);
    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    wire logic [7:0] cfg1 = FILTER_AND_TEST_CONFIG;
    wire logic [7:0] cfg2 = SIGNALING_AND_LAW_CONFIG;
    // ----
    // Checks
    // ----
    a_reset_cfg_vals: assert property ($rose(RSTN) |-> cfg1 == 8'h00 && cfg2 == 8'hFF)
        else $error("config not at reset values");
    a_reply_cfg_tail: assert property ($fell(TX_VALID) |->
        $past(TX_BYTE, 2) == cfg2 && $past(TX_BYTE) == cfg1) else $error("reply tail wrong");
    a_reply_has_cause: assert property ($rose(TX_VALID) |->
        $past(RX_VALID) || $past(RX_VALID, 2)) else $error("reply without request");
    a_reply_min_two: assert property ($rose(TX_VALID) |=> TX_VALID)
        else $error("reply shorter than two bytes");
    // Registered copies settle a cycle apart, so wait for a quiet register
    a_test_mode_map: assert property ($stable(cfg1) [*3] |-> TEST_MODE ==
        ((cfg1[2:1] == 2'h2) ? 3'h0 : cfg1[2:0])) else $error("test mode mismatch");
    a_law_select_map: assert property ($stable(cfg2) [*3] |->
        MU_LAW == cfg2[1] && FIXED_BALANCE == cfg2[0]) else $error("law select mismatch");
    a_pin_dir_map: assert property ($stable(cfg2) [*3] |->
        SIG_PIN_OE == (~cfg2[7:4] & (4'hE | {3'h0, cfg2[2]}))) else $error("pin enable wrong");
    // Expansion bit only passes while expansion logic is marked attached
    a_sig_rx_latch: assert property (SIG_RX_VALID |=>
        {SIG_OUT_PINS, SIG_PIN_OUT} == $past(SIG_RX_BYTE[7:1])
        && SIG_EXP_OUT == ($past(SIG_RX_BYTE[0]) & cfg2[3])) else $error("rx sig bad");
    a_sig_tx_mask: assert property ($stable(cfg2) [*3] |->
        (SIG_TX_BYTE[4:1] & SIG_PIN_OE) == 4'h0 && !SIG_TX_BYTE[0]) else $error("tx sig bad");
    c_reply_done: cover property ($fell(TX_VALID));
    c_sig_rx: cover property (SIG_RX_VALID);
    c_two_codec: cover property (!cfg2[2]);
endmodule // ccbi_top_chk
`default_nettype wire

// ### sim/ccbi_top_tb_top.sv
// Self-checking bench for the codec control byte interpreter
`timescale 1ns/1ps
`default_nettype none
module ccbi_top_tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] sig_rx_byte = 8'h00;
    logic sig_rx_valid = 1'b0;
    logic [2:0] sig_in_pins = 3'h0;
    logic [3:0] pin_ext = 4'h0;
    logic [7:0] voice_a = 8'h00;
    logic [7:0] voice_b = 8'h00;
    logic [7:0] rq[$];
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    wire logic [7:0] rx_byte, tx_byte, sig_tx_byte, voice_sum, cfg1, cfg2;
    wire logic [3:0] sig_pin_in, pin_out, pin_oe;
    wire logic [2:0] out_pins, test_mode;
    wire logic rx_valid, tx_valid, exp_out, power_up, mu_law, fixed_bal;
    // Pins D..A take the level of whichever side enables its driver
    assign sig_pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
    always #25 clk_sys = ~clk_sys;
    ccbi_ctrl_model u_ccbi_ctrl_model (.clk(clk_sys), .rx_byte(rx_byte), .rx_valid(rx_valid));
    ccbi_top u_ccbi_top (
        .CLK_SYS(clk_sys), .RSTN(rstn), .RX_BYTE(rx_byte), .RX_VALID(rx_valid),
        .SIG_RX_BYTE(sig_rx_byte), .SIG_RX_VALID(sig_rx_valid), .SIG_IN_PINS(sig_in_pins),
        .SIG_PIN_IN(sig_pin_in), .VOICE_A(voice_a), .VOICE_B(voice_b), .TX_BYTE(tx_byte),
        .TX_VALID(tx_valid), .SIG_TX_BYTE(sig_tx_byte), .SIG_OUT_PINS(out_pins),
        .SIG_PIN_OUT(pin_out), .SIG_PIN_OE(pin_oe), .SIG_EXP_OUT(exp_out),
        .VOICE_SUM(voice_sum), .POWER_UP(power_up), .FILTER_AND_TEST_CONFIG(cfg1),
        .SIGNALING_AND_LAW_CONFIG(cfg2), .TEST_MODE(test_mode), .MU_LAW(mu_law),
        .FIXED_BALANCE(fixed_bal));
    // ----
    // Helpers
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    begin
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task automatic tx(input logic [7:0] b);
    begin
        u_ccbi_ctrl_model.send(b);
    end
    endtask
    task automatic wt(input int n);
    begin
        repeat (n) @(posedge clk_sys);
        #1;
    end
    endtask
    task automatic wr2(input logic [7:0] c2, input logic [7:0] c1);
    begin
        tx(8'h26);
        tx(c2);
        tx(c1);
        wt(4);
    end
    endtask
    // Reply window is wide enough for the longest block plus both registers
    task automatic rd(input logic [7:0] cmd, input int n);
    begin
        tx(cmd);
        // First reply byte stands in the cycle right after the command edge
        #1;
        rq.delete();
        repeat (24)
        begin
            if (tx_valid === 1'b1)
                rq.push_back(tx_byte);
            wt(1);
        end
        chk(8'(rq.size()), 8'(n));
    end
    endtask
    task automatic close_out;
    begin
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            close_out;
        end
    end
    // ----
    // Scenarios
    // ----
    task automatic t_basic;
    begin
        chk(cfg1, 8'h00);
        chk(cfg2, 8'hFF);
        chk({power_up, mu_law, fixed_bal, pin_oe}, 8'h30);
        wr2(8'h0E, 8'h80);
        chk(cfg2, 8'h0E);
        chk(cfg1, 8'h80);
        chk({power_up, mu_law, fixed_bal, pin_oe}, 8'h6F);
        rd(8'h66, 2);
        chk(rq[0], 8'h0E);
        chk(rq[1], 8'h80);
        for (int i = 0; i < 8; i++)
        begin
            tx(8'h27);
            tx(8'h78 | 8'(i));
            wt(4);
            chk(test_mode, (i == 4 || i == 5) ? 8'h00 : 8'(i));
            chk(cfg1, 8'h78 | 8'(i));
            chk(cfg2, 8'h0E);
        end
        tx(8'h25);
        tx(8'h0C);
        rd(8'hE6, 0);
        chk(cfg1, 8'h7F);
        $display("t_basic done");
    end
    endtask
    task automatic t_coef;
        logic [7:0] wc[7] = '{8'h03, 8'h0B, 8'h18, 8'h13, 8'h23, 8'h2B, 8'h30};
        int nb[7] = '{8, 8, 4, 8, 8, 8, 4};
    begin
        for (int k = 0; k < 7; k++)
        begin
            tx(wc[k]);
            for (int j = 0; j < nb[k]; j++)
                tx(8'(k * 16 + j + 1));
        end
        for (int k = 0; k < 7; k++)
        begin
            rd(wc[k] + 8'h40, nb[k] + 2);
            for (int j = 0; j < nb[k]; j++)
                chk(rq[j], 8'(k * 16 + j + 1));
            chk(rq[nb[k]], 8'h0E);
            chk(rq[nb[k] + 1], 8'h7F);
        end
        $display("t_coef done");
    end
    endtask
    task automatic t_sig;
    begin
        @(posedge clk_sys);
        voice_a <= 8'h90;
        voice_b <= 8'h80;
        sig_rx_byte <= 8'hA5;
        sig_rx_valid <= 1'b1;
        sig_in_pins <= 3'h6;
        @(posedge clk_sys);
        sig_rx_valid <= 1'b0;
        sig_rx_byte <= 8'h5A;
        tx(8'h34);
        wt(8);
        chk({out_pins, pin_out, exp_out}, 8'hA5);
        chk(sig_tx_byte, 8'hC0);
        chk(voice_sum, 8'h10);
        tx(8'h04);
        wt(4);
        chk(power_up, 8'h00);
        chk(voice_sum, 8'h90);
        wr2(8'hF4, 8'h7F);
        @(posedge clk_sys);
        pin_ext <= 4'h5;
        wt(8);
        chk(sig_tx_byte, 8'hCA);
        @(posedge clk_sys);
        sig_rx_byte <= 8'h0B;
        sig_rx_valid <= 1'b1;
        @(posedge clk_sys);
        sig_rx_valid <= 1'b0;
        wt(2);
        chk({out_pins, pin_out, exp_out}, 8'h0A);
        chk({power_up, pin_oe, mu_law, fixed_bal}, 8'h40);
        $display("t_sig done");
    end
    endtask
    task automatic t_two;
    begin
        wr2(8'h00, 8'h7F);
        chk(pin_oe, 8'h0E);
        rd(8'h66, 0);
        rd(8'hE6, 2);
        chk(rq[0], 8'h00);
        @(posedge clk_sys);
        pin_ext <= 4'h0;
        wt(8);
        rd(8'h66, 2);
        wr2(8'h0E, 8'h7F);
        chk(cfg2, 8'h0E);
        $display("t_two done");
    end
    endtask
    task automatic t_reset;
    begin
        @(posedge clk_sys);
        rstn <= 1'b0;
        wt(2);
        chk(cfg1, 8'h00);
        chk(cfg2, 8'hFF);
        chk(power_up, 8'h00);
        @(posedge clk_sys);
        rstn <= 1'b1;
        wt(2);
        rd(8'h66, 2);
        chk(rq[0], 8'hFF);
        chk(rq[1], 8'h00);
        $display("t_reset done");
    end
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        wt(1);
        t_basic;
        t_coef;
        t_sig;
        t_two;
        t_reset;
        close_out;
    end
endmodule // ccbi_top_tb_top
bind ccbi_top ccbi_top_chk u_ccbi_top_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .RX_VALID(RX_VALID), .SIG_RX_BYTE(SIG_RX_BYTE), .SIG_RX_VALID(SIG_RX_VALID),
    .TX_BYTE(TX_BYTE), .TX_VALID(TX_VALID), .SIG_TX_BYTE(SIG_TX_BYTE),
    .SIG_OUT_PINS(SIG_OUT_PINS), .SIG_PIN_OUT(SIG_PIN_OUT), .SIG_PIN_OE(SIG_PIN_OE),
    .SIG_EXP_OUT(SIG_EXP_OUT), .FILTER_AND_TEST_CONFIG(FILTER_AND_TEST_CONFIG),
    .SIGNALING_AND_LAW_CONFIG(SIGNALING_AND_LAW_CONFIG), .TEST_MODE(TEST_MODE),
    .MU_LAW(MU_LAW), .FIXED_BALANCE(FIXED_BALANCE));
`default_nettype wire
